/* File: hw/appo_pkg.sv */
package appo_pkg;

    // ****************************************************************
    // Clock and timing
    // ****************************************************************
    localparam int unsigned CLK_HZ          = 20_000_000;
    localparam int unsigned BAUD_BPS        = 9_600;
    localparam int unsigned BIT_CYCLES      = CLK_HZ / BAUD_BPS;
    localparam int unsigned BIT_CNT_W       = 12;
    // Base pulse rate in kpps at the top of a setting range
    localparam int unsigned BASE_KPPS       = 680;
    // Pulse period in cycles = CLK_HZ*range/(BASE_KPPS*1000*setting)
    localparam int unsigned BASE_PPS        = BASE_KPPS * 1000;
    // Longest train time for the lowest range, doubled per range
    localparam int unsigned TRAIN_MAX_MS    = 25;
    localparam int unsigned TRAIN_MAX_CYC   = CLK_HZ / 1000 * TRAIN_MAX_MS;

    // ****************************************************************
    // Settings
    // ****************************************************************
    localparam int unsigned PPR_W           = 21;
    localparam int unsigned POS_W           = 21;
    localparam int unsigned MT_W            = 17;
    localparam int unsigned ABS_W           = 40;
    localparam int unsigned RANGE_LOW_LOG2  = 14;
    localparam int unsigned RANGE_HIGH_LOG2 = 20;
    localparam logic [1:0]  USAGE_MULTI     = 2'h0;
    localparam logic [1:0]  USAGE_INCR      = 2'h1;
    localparam logic [1:0]  USAGE_SINGLE    = 2'h2;

    // ****************************************************************
    // Serial message
    // ****************************************************************
    localparam int unsigned MSG_CHARS       = 8;
    localparam int unsigned MSG_DIGITS      = 5;
    localparam int unsigned FRAME_BITS      = 10;
    localparam logic [6:0]  CH_P            = 7'h50;
    localparam logic [6:0]  CH_PLUS         = 7'h2b;
    localparam logic [6:0]  CH_MINUS        = 7'h2d;
    localparam logic [6:0]  CH_ZERO         = 7'h30;
    localparam logic [6:0]  CH_CR           = 7'h0d;

    typedef enum logic [2:0] {
        APPO_IDLE  = 3'h0,
        APPO_MSG   = 3'h1,
        APPO_TRAIN = 3'h2,
        APPO_INCR  = 3'h3,
        APPO_OFF   = 3'h4
    } appo_state_t;

endpackage : appo_pkg

/* File: hw/appo_uart_tx.sv */
`timescale 1ns/1ps
module appo_uart_tx (
    input  wire logic       clock_in,
    input  wire logic       rst_b_in,
    input  wire logic       start_in,
    input  wire logic [6:0] char_in,
    output logic            busy_out,
    output logic            tx_out
);
    logic [appo_pkg::BIT_CNT_W-1:0] div_reg, div_next;
    logic [3:0]                     bit_reg, bit_next;
    logic [9:0]                     shf_reg, shf_next;
    logic                           busy_reg, busy_next;

    // ****************************************************************
    // Framing: start, seven data bits LSB first, even parity, stop
    // ****************************************************************
    always_comb begin
        div_next  = div_reg;
        bit_next  = bit_reg;
        shf_next  = shf_reg;
        busy_next = busy_reg;
        if (!busy_reg) begin
            if (start_in) begin
                shf_next  = {1'b1, ^char_in, char_in, 1'b0}; // [R15]
                busy_next = 1'b1;
                div_next  = '0;
                bit_next  = '0;
            end
        end else if (div_reg ==
                     appo_pkg::BIT_CNT_W'(appo_pkg::BIT_CYCLES - 1)) begin
            div_next = '0;
            shf_next = {1'b1, shf_reg[9:1]};
            if (bit_reg == 4'(appo_pkg::FRAME_BITS - 1)) begin
                busy_next = 1'b0;
            end else begin
                bit_next = bit_reg + 4'h1;
            end
        end else begin
            div_next = div_reg + 1'b1;
        end
    end

    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            div_reg  <= '0;
            bit_reg  <= 4'h0;
            shf_reg  <= 10'h3ff;
            busy_reg <= 1'b0;
        end else begin
            div_reg  <= div_next;
            bit_reg  <= bit_next;
            shf_reg  <= shf_next;
            busy_reg <= busy_next;
        end
    end

    assign busy_out = busy_reg;
    assign tx_out   = busy_reg ? shf_reg[0] : 1'b1;

endmodule : appo_uart_tx

/* File: hw/appo_top.sv */
`timescale 1ns/1ps
// Overview of operation
// R1: Absolute position is multiturn count times pulses per rev plus the position within the rev.
// R2: A single-turn encoder, real or configured, reports a multiturn count of zero.
// R3: Phase A sends the multiturn message, then the in-rev pulse train, then incremental pulses.
// R4: Phase B sends the in-rev pulse train, then incremental pulses.
// R5: Phase C carries only the origin pulse, independent of the transfer sequence.
// R6: Data goes out only after power-up, each transfer started by the sensor-on command.
// R7: The sent position is the current stop position, then incremental operation follows.
// R8: The host receives the multiturn message with an asynchronous serial receiver.
// R9: The host counter ignores the message on phase A alone and counts from the pulse train.
// R10: The host issues sensor-off before removing control power.
// R11: Train rate is 680 kpps times the setting over the power-of-two top of its range.
// R12: The train lasts at most 25 ms in the lowest range, doubling up to 1600 ms.
// R13: Usage value 2 means single-turn absolute and takes effect only after restart.
// R14: With a multiturn encoder usage 0 selects multiturn absolute and 1 incremental.
// R15: The message is 9600 bps, one start, one stop, even parity, 7-bit ASCII.
// R16: The message is P, a sign, five decimal digits of count, and a carriage return.
module appo_top (
    input  wire logic        clock_in,
    input  wire logic        rst_b_in,
    input  wire logic        sensor_on_cmd_in,
    input  wire logic        sensor_off_cmd_in,
    input  wire logic        encoder_multiturn_in,
    input  wire logic [1:0]  encoder_usage_setting_in,
    input  wire logic [20:0] pulses_per_rev_setting_in,
    input  wire logic [16:0] multiturn_count_in,
    input  wire logic        multiturn_neg_in,
    input  wire logic [20:0] rev_position_in,
    input  wire logic        enc_a_in,
    input  wire logic        enc_b_in,
    input  wire logic        enc_origin_in,
    output logic             phase_a_out,
    output logic             phase_b_out,
    output logic             phase_c_origin_out,
    output logic             absolute_mode_out,
    output logic             transfer_busy_out,
    output logic [39:0]      absolute_position_out
);
    typedef logic [appo_pkg::POS_W-1:0] appo_pos_t;

    appo_pkg::appo_state_t state_reg, state_next;
    logic [1:0]            usage_reg, usage_next;
    logic                  cfg_done_reg, cfg_done_next;
    logic                  son_reg, son_next;
    logic [3:0]            chr_reg, chr_next;
    logic [16:0]           mt_reg, mt_next;
    logic                  neg_reg, neg_next;
    appo_pos_t             pos_reg, pos_next;
    appo_pos_t             cnt_reg, cnt_next;
    logic [31:0]           acc_reg, acc_next;
    logic [1:0]            quad_reg, quad_next;
    logic [31:0]           tmr_reg, tmr_next;
    logic                  a_reg, a_next;
    logic                  b_reg, b_next;
    logic                  c_reg, c_next;
    logic [39:0]           abs_reg, abs_next;
    logic                  tx_start;
    logic [6:0]            tx_char;
    logic                  tx_busy;
    logic                  tx_line;
    logic                  son_rise;
    logic                  single_turn;
    logic [2:0]            range_idx;
    logic [31:0]           step;
    logic [31:0]           pulse_thr;
    logic [31:0]           train_limit;

    // ****************************************************************
    // Helpers
    // ****************************************************************
    // Range index 0..6 from the power-of-two top of the setting's range
    function automatic logic [2:0] appo_range(input logic [20:0] ppr);
        logic [2:0] r;
        r = 3'h0;
        for (int i = appo_pkg::RANGE_HIGH_LOG2;
             i > appo_pkg::RANGE_LOW_LOG2; i--) begin
            if (ppr > (21'h1 << (i - 1)) && r == 3'h0) begin
                r = 3'(i - appo_pkg::RANGE_LOW_LOG2);
            end
        end
        return r;
    endfunction : appo_range

    // Decimal digit k (0 = most significant of five) of v
    function automatic logic [6:0] appo_digit(input logic [16:0] v,
                                              input logic [2:0]  k);
        logic [16:0] q;
        q = v;
        for (int i = 0; i < 4 - int'(k); i++) begin
            q = q / 17'd10;
        end
        return appo_pkg::CH_ZERO + 7'(q % 17'd10);
    endfunction : appo_digit

    assign single_turn = !encoder_multiturn_in ||
                         usage_reg == appo_pkg::USAGE_SINGLE; // [R2] [R13]
    assign absolute_mode_out = usage_reg != appo_pkg::USAGE_INCR ||
                               !encoder_multiturn_in;      // [R14]
    assign range_idx = appo_range(pulses_per_rev_setting_in);
    // Accumulator adds the setting and wraps at a point that scales with
    // the range top, so small settings keep their resolution [R11]
    assign step = 32'(pulses_per_rev_setting_in);
    assign pulse_thr = 32'(appo_pkg::CLK_HZ / 1000 * 64
                           / appo_pkg::BASE_KPPS) << (4'(range_idx) + 4'h6);
    assign train_limit = 32'(appo_pkg::TRAIN_MAX_CYC) << range_idx; // [R12]
    assign son_rise = sensor_on_cmd_in && !son_reg;

    // ****************************************************************
    // Message characters
    // ****************************************************************
    always_comb begin
        unique case (chr_reg)
            4'h0: tx_char = appo_pkg::CH_P;                          // [R16]
            4'h1: tx_char = neg_reg ? appo_pkg::CH_MINUS : appo_pkg::CH_PLUS;
            4'h7: tx_char = appo_pkg::CH_CR;
            default: tx_char = appo_digit(mt_reg, 3'(chr_reg - 4'h2));
        endcase
    end
    assign tx_start = state_reg == appo_pkg::APPO_MSG && !tx_busy &&
                      chr_reg != 4'(appo_pkg::MSG_CHARS);

    appo_uart_tx u_tx (
        .clock_in (clock_in),
        .rst_b_in (rst_b_in),
        .start_in (tx_start),
        .char_in  (tx_char),
        .busy_out (tx_busy),
        .tx_out   (tx_line)
    );

    // ****************************************************************
    // Sequence
    // ****************************************************************
    always_comb begin
        state_next    = state_reg;
        usage_next    = usage_reg;
        cfg_done_next = 1'b1;
        son_next      = sensor_on_cmd_in;
        chr_next      = chr_reg;
        mt_next       = mt_reg;
        neg_next      = neg_reg;
        pos_next      = pos_reg;
        cnt_next      = cnt_reg;
        acc_next      = acc_reg;
        quad_next     = quad_reg;
        tmr_next      = tmr_reg;
        abs_next      = abs_reg;
        a_next        = a_reg;
        b_next        = b_reg;
        // Usage captured once after reset: later changes need a restart
        if (!cfg_done_reg) begin
            usage_next = encoder_usage_setting_in;             // [R13]
        end
        c_next = enc_origin_in;                                // [R5]
        unique case (state_reg)
            appo_pkg::APPO_IDLE, appo_pkg::APPO_OFF: begin
                a_next = 1'b1;
                b_next = 1'b0;
                if (son_rise && cfg_done_reg) begin            // [R6]
                    // Latch the stop position at the command [R7]
                    mt_next  = single_turn ? 17'h0 : multiturn_count_in;
                    neg_next = single_turn ? 1'b0 : multiturn_neg_in;
                    pos_next = rev_position_in;
                    abs_next = 40'(single_turn ? 17'h0 : multiturn_count_in)
                               * 40'(pulses_per_rev_setting_in)
                               + 40'(rev_position_in);         // [R1]
                    chr_next = 4'h0;
                    cnt_next = '0;
                    acc_next = '0;
                    tmr_next = '0;
                    quad_next = 2'h0;
                    state_next = absolute_mode_out ? appo_pkg::APPO_MSG
                                                   : appo_pkg::APPO_INCR;
                end
            end
            appo_pkg::APPO_MSG: begin
                a_next = tx_line;                              // [R3]
                b_next = 1'b0;
                if (tx_start) begin
                    chr_next = chr_reg + 4'h1;
                end
                // Wait out the stop bit of the last character first
                if (chr_reg == 4'(appo_pkg::MSG_CHARS) && !tx_busy) begin
                    state_next = appo_pkg::APPO_TRAIN;
                end
            end
            appo_pkg::APPO_TRAIN: begin
                // Each overflow of the accumulator is one quadrature edge
                tmr_next = tmr_reg + 32'h1;
                acc_next = acc_reg + step;
                if (acc_next >= pulse_thr) begin
                    acc_next = acc_next - pulse_thr;
                    if (cnt_reg != pos_reg) begin
                        quad_next = quad_reg + 2'h1;
                        if (quad_reg == 2'h3) begin
                            cnt_next = cnt_reg + 1'b1;
                        end
                    end
                end
                a_next = quad_reg == 2'h1 || quad_reg == 2'h2; // [R3]
                b_next = quad_reg[1];                          // [R4]
                if ((cnt_reg == pos_reg && quad_reg == 2'h0) ||
                    tmr_reg >= train_limit) begin              // [R12]
                    state_next = appo_pkg::APPO_INCR;          // [R7]
                end
            end
            appo_pkg::APPO_INCR: begin
                a_next = enc_a_in;                             // [R3]
                b_next = enc_b_in;                             // [R4]
            end
            default: state_next = appo_pkg::APPO_IDLE;
        endcase
        // Abort overrides any step taken above
        if (sensor_off_cmd_in) begin
            state_next = appo_pkg::APPO_OFF;
        end
    end

    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            state_reg    <= appo_pkg::APPO_IDLE;
            usage_reg    <= appo_pkg::USAGE_MULTI;
            cfg_done_reg <= 1'b0;
            son_reg      <= 1'b0;
            chr_reg      <= 4'h0;
            mt_reg       <= 17'h0;
            neg_reg      <= 1'b0;
            pos_reg      <= '0;
            cnt_reg      <= '0;
            acc_reg      <= 32'h0;
            quad_reg     <= 2'h0;
            tmr_reg      <= 32'h0;
            abs_reg      <= 40'h0;
            a_reg        <= 1'b1;
            b_reg        <= 1'b0;
            c_reg        <= 1'b0;
        end else begin
            state_reg    <= state_next;
            usage_reg    <= usage_next;
            cfg_done_reg <= cfg_done_next;
            son_reg      <= son_next;
            chr_reg      <= chr_next;
            mt_reg       <= mt_next;
            neg_reg      <= neg_next;
            pos_reg      <= pos_next;
            cnt_reg      <= cnt_next;
            acc_reg      <= acc_next;
            quad_reg     <= quad_next;
            tmr_reg      <= tmr_next;
            abs_reg      <= abs_next;
            a_reg        <= a_next;
            b_reg        <= b_next;
            c_reg        <= c_next;
        end
    end

    assign phase_a_out           = a_reg;
    assign phase_b_out           = b_reg;
    assign phase_c_origin_out    = c_reg;
    assign transfer_busy_out     = state_reg == appo_pkg::APPO_MSG ||
                                   state_reg == appo_pkg::APPO_TRAIN;
    assign absolute_position_out = abs_reg;

endmodule : appo_top

/* File: verification/appo_top_assertions.sv */
`timescale 1ns/1ps
module appo_chk (
    input  wire logic        clock_in,
    input  wire logic        rst_b_in,
    input  wire logic        sensor_on_cmd_in,
    input  wire logic        sensor_off_cmd_in,
    input  wire logic        encoder_multiturn_in,
    input  wire logic [1:0]  encoder_usage_setting_in,
    input  wire logic [20:0] pulses_per_rev_setting_in,
    input  wire logic [16:0] multiturn_count_in,
    input  wire logic        multiturn_neg_in,
    input  wire logic [20:0] rev_position_in,
    input  wire logic        enc_a_in,
    input  wire logic        enc_b_in,
    input  wire logic        enc_origin_in,
    input  wire logic        phase_a_out,
    input  wire logic        phase_b_out,
    input  wire logic        phase_c_origin_out,
    input  wire logic        absolute_mode_out,
    input  wire logic        transfer_busy_out,
    input  wire logic [39:0] absolute_position_out
);
    // ****************
    // Helper state
    // ****************
    // Message is 80 bit times; margin keeps the bound clear of the train
    localparam int unsigned MSG_CYC = 166000;
    logic [1:0]  edge_reg;
    logic [1:0]  edge_next;
    logic [1:0]  usage_reg;
    logic [1:0]  usage_next;
    logic [17:0] msg_reg;
    logic [17:0] msg_next;
    logic [39:0] exp_pos;
    logic [16:0] mt_eff;

    always_comb begin
        edge_next  = (edge_reg == 2'h3) ? edge_reg : edge_reg + 2'h1;
        usage_next = (edge_reg == 2'h0) ? encoder_usage_setting_in
                                        : usage_reg;
        msg_next   = transfer_busy_out ? msg_reg + 18'h1 : 18'h0;
        mt_eff     = (usage_reg == appo_pkg::USAGE_SINGLE ||
                      !encoder_multiturn_in) ? 17'h0 : multiturn_count_in;
        exp_pos    = 40'(mt_eff) * 40'(pulses_per_rev_setting_in)
                   + 40'(rev_position_in);
    end

    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            edge_reg  <= 2'h0;
            usage_reg <= 2'h0;
            msg_reg   <= 18'h0;
        end else begin
            edge_reg  <= edge_next;
            usage_reg <= usage_next;
            msg_reg   <= msg_next;
        end
    end

    // ****************
    // Properties
    // ****************
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!rst_b_in);

    sequence taken_s;
        $rose(transfer_busy_out);
    endsequence
    sequence start_bit_s;
        ##[0:3] !phase_a_out;
    endsequence

    a_origin_copy: assert property (edge_reg != 2'h0 |->
        phase_c_origin_out == $past(enc_origin_in))
        else $error("origin output is not the delayed origin input");
    a_start_cmd: assert property (taken_s |->
        $past(sensor_on_cmd_in))
        else $error("transfer began without sensor-on");
    a_start_bit: assert property (taken_s |-> start_bit_s)
        else $error("no start bit after transfer began");
    a_b_quiet: assert property (transfer_busy_out &&
        msg_reg < MSG_CYC |-> !phase_b_out)
        else $error("phase b moved during the message");
    a_mode_fixed: assert property (edge_reg == 2'h3 |->
        $stable(absolute_mode_out))
        else $error("mode changed without restart");
    a_mode_usage: assert property (edge_reg == 2'h3 |->
        absolute_mode_out == (usage_reg != appo_pkg::USAGE_INCR))
        else $error("mode does not match captured usage");
    a_incr_quiet: assert property (!absolute_mode_out |->
        !transfer_busy_out)
        else $error("transfer in incremental usage");
    a_pos_value: assert property (taken_s |->
        ##[0:2] absolute_position_out == exp_pos)
        else $error("absolute position value wrong");
    a_pos_hold: assert property (transfer_busy_out &&
        $past(transfer_busy_out) |-> $stable(absolute_position_out))
        else $error("position moved during transfer");
    a_off_abort: assert property (sensor_off_cmd_in |->
        ##[1:3] !transfer_busy_out)
        else $error("sensor-off did not stop the transfer");
endmodule : appo_chk

bind appo_top appo_chk i_appo_chk (
    .clock_in, .rst_b_in, .sensor_on_cmd_in, .sensor_off_cmd_in,
    .encoder_multiturn_in, .encoder_usage_setting_in,
    .pulses_per_rev_setting_in, .multiturn_count_in, .multiturn_neg_in,
    .rev_position_in, .enc_a_in, .enc_b_in, .enc_origin_in, .phase_a_out,
    .phase_b_out, .phase_c_origin_out, .absolute_mode_out,
    .transfer_busy_out, .absolute_position_out
);

/* File: verification/appo_host_model.sv */
`timescale 1ns/1ps
module appo_host_model (
    input  wire logic   clock_in,
    input  wire logic   clear_in,
    input  wire logic   phase_a_in,
    input  wire logic   phase_b_in,
    output logic [55:0] chars_out,
    output logic [3:0]  nchar_out,
    output logic        bad_frame_out,
    output logic [20:0] count_out,
    output logic [15:0] period_out
);
    // ****************
    // Receiver and quadrature counter
    // ****************
    localparam int unsigned BIT = appo_pkg::BIT_CYCLES;
    logic [8:0]  bits;
    logic        b_d;
    logic [15:0] gap;

    // Samples mid-bit; stops after one full message
    always begin
        @(posedge clock_in);
        if (clear_in) begin
            nchar_out = 4'h0;
            bad_frame_out = 1'b0;
        end else if (nchar_out < 4'h8 && !phase_a_in) begin
            repeat (BIT / 2) @(posedge clock_in);
            for (int i = 0; i < 9; i++) begin
                repeat (BIT) @(posedge clock_in);
                bits[i] = phase_a_in;
            end
            if ((^bits[7:0]) || !bits[8]) bad_frame_out = 1'b1;
            chars_out = {chars_out[48:0], bits[6:0]};
            nchar_out = nchar_out + 4'h1;
        end
    end

    // Counting is held off until the message is complete
    always @(posedge clock_in) begin
        b_d <= phase_b_in;
        gap <= gap + 16'h1;
        if (clear_in) begin
            count_out <= 21'h0;
            gap <= 16'h0;
        end else if (phase_b_in && !b_d && nchar_out == 4'h8) begin
            count_out <= phase_a_in ? count_out + 21'h1 : count_out - 21'h1;
            period_out <= gap;
            gap <= 16'h1;
        end
    end
endmodule : appo_host_model

/* File: verification/test_absolute_position_pulse_output.sv */
`timescale 1ns/1ps
module test_absolute_position_pulse_output;
    logic        clock_in = 1'b0;
    logic        rst_b_in = 1'b0;
    logic        sensor_on_cmd_in = 1'b0;
    logic        sensor_off_cmd_in = 1'b0;
    logic        encoder_multiturn_in = 1'b1;
    logic [1:0]  encoder_usage_setting_in = 2'h0;
    logic [20:0] pulses_per_rev_setting_in = 21'h4000;
    logic [16:0] multiturn_count_in = 17'h7b;
    logic        multiturn_neg_in = 1'b0;
    logic [20:0] rev_position_in = 21'h5;
    logic        enc_a_in = 1'b0;
    logic        enc_b_in = 1'b0;
    logic        enc_origin_in = 1'b0;
    logic        clear = 1'b1;
    logic        phase_a_out, phase_b_out, phase_c_origin_out;
    logic        absolute_mode_out, transfer_busy_out, bad_frame;
    logic [39:0] absolute_position_out;
    logic [55:0] chars;
    logic [3:0]  nchar;
    logic [20:0] count;
    logic [15:0] period;
    int          bad_count = 0;
    int          tests_run = 0;
    int          cycles = 0;

    appo_top i_appo_top (.clock_in, .rst_b_in, .sensor_on_cmd_in,
        .sensor_off_cmd_in, .encoder_multiturn_in, .encoder_usage_setting_in,
        .pulses_per_rev_setting_in, .multiturn_count_in, .multiturn_neg_in,
        .rev_position_in, .enc_a_in, .enc_b_in, .enc_origin_in, .phase_a_out,
        .phase_b_out, .phase_c_origin_out, .absolute_mode_out,
        .transfer_busy_out, .absolute_position_out);
    appo_host_model i_appo_host_model (.clock_in, .clear_in(clear),
        .phase_a_in(phase_a_out), .phase_b_in(phase_b_out), .chars_out(chars),
        .nchar_out(nchar), .bad_frame_out(bad_frame), .count_out(count),
        .period_out(period));

    always #25 clock_in = ~clock_in;

    // Full message alone is some 167k cycles
    always @(posedge clock_in) begin
        cycles <= cycles + 1;
        if (cycles == 400000) begin
            bad_count++;
            wrap_up();
        end
    end

    // ****************
    // Shared tasks
    // ****************
    task automatic check(input string what, input logic [55:0] seen,
                         input logic [55:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic tick(input int n);
        repeat (n) @(posedge clock_in);
        #5;
    endtask : tick

    task automatic do_reset(input logic [1:0] usage, input logic multi);
        rst_b_in = 1'b0;
        sensor_on_cmd_in = 1'b0;
        sensor_off_cmd_in = 1'b0;
        encoder_usage_setting_in = usage;
        encoder_multiturn_in = multi;
        tick(20);
        rst_b_in = 1'b1;
        tick(3);
    endtask : do_reset

    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : wrap_up

    // ****************
    // Scenarios
    // ****************
    task automatic s_reset;
        do_reset(appo_pkg::USAGE_MULTI, 1'b1);
        check("idle a", phase_a_out, 1'b1);
        check("idle b", phase_b_out, 1'b0);
        tick(30);
        check("no cmd", transfer_busy_out, 1'b0);
    endtask : s_reset

    task automatic s_incr;
        do_reset(appo_pkg::USAGE_INCR, 1'b1);
        check("incr mode", absolute_mode_out, 1'b0);
        sensor_on_cmd_in = 1'b1;
        enc_a_in = 1'b0;
        enc_origin_in = 1'b1;
        tick(3);
        check("incr busy", transfer_busy_out, 1'b0);
        check("incr a", phase_a_out, 1'b0);
        check("origin", phase_c_origin_out, 1'b1);
        encoder_usage_setting_in = appo_pkg::USAGE_MULTI;
        enc_a_in = 1'b1;
        enc_origin_in = 1'b0;
        tick(3);
        check("usage late", absolute_mode_out, 1'b0);
        check("incr a2", phase_a_out, 1'b1);
        check("origin low", phase_c_origin_out, 1'b0);
    endtask : s_incr

    task automatic s_single(input logic [1:0] usage, input logic multi);
        do_reset(usage, multi);
        rev_position_in = 21'h7;
        sensor_on_cmd_in = 1'b1;
        tick(3);
        check("single busy", transfer_busy_out, 1'b1);
        check("single pos", absolute_position_out, 40'h7);
        sensor_off_cmd_in = 1'b1;
        tick(3);
        check("abort busy", transfer_busy_out, 1'b0);
        check("abort a", phase_a_out, 1'b1);
    endtask : s_single

    task automatic s_full;
        int m;
        clear = 1'b1;
        do_reset(appo_pkg::USAGE_MULTI, 1'b1);
        rev_position_in = 21'h5;
        enc_a_in = 1'b0;
        clear = 1'b0;
        sensor_on_cmd_in = 1'b1;
        tick(3);
        check("busy", transfer_busy_out, 1'b1);
        check("mode", absolute_mode_out, 1'b1);
        check("pos", absolute_position_out, 40'h1ec005);
        m = 0;
        while (transfer_busy_out === 1'b1 && m < appo_pkg::TRAIN_MAX_CYC) begin
            tick(1);
            if (nchar == 4'h8) m++;
        end
        check("train end", transfer_busy_out, 1'b0);
        check("chars", chars, {7'h50, 7'h2b, 7'h30, 7'h30,
                               7'h31, 7'h32, 7'h33, 7'h0d});
        check("frame", bad_frame, 1'b0);
        check("pulses", count, 21'h5);
        check("rate", period inside {[29:30]}, 1'b1);
        enc_a_in = 1'b1;
        tick(3);
        check("inc a", phase_a_out, 1'b1);
        enc_b_in = 1'b1;
        tick(3);
        check("inc b", phase_b_out, 1'b1);
        sensor_on_cmd_in = 1'b0;
        tick(2);
        sensor_on_cmd_in = 1'b1;
        tick(3);
        check("refused", transfer_busy_out, 1'b0);
    endtask : s_full

    initial begin
        s_reset();
        s_incr();
        s_single(appo_pkg::USAGE_SINGLE, 1'b1);
        s_single(appo_pkg::USAGE_MULTI, 1'b0);
        s_full();
        wrap_up();
    end
endmodule : test_absolute_position_pulse_output
